/* core/dcd_pkg.sv */
package dcd_pkg;
   // command line encoding {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_NOP   = 4'h7;
   localparam logic [3:0] CMD_RDWR  = 4'h5;
   localparam logic [3:0] CMD_WR    = 4'h4;
   localparam logic [3:0] CMD_ACT   = 4'h3;
   localparam logic [3:0] CMD_PRE   = 4'h2;
   localparam logic [3:0] CMD_REF   = 4'h1;
   localparam logic [3:0] CMD_MRS   = 4'h0;
   localparam logic [3:0] CMD_ZQ    = 4'h6;
   // address bit positions
   localparam int AP_BIT = 10;
   localparam int BC_BIT = 12;
   // read-to-data latency, fastest bin, in picoseconds
   localparam int TAA_MIN_PS = 13910;
   localparam int TAA_MAX_PS = 20000;
   localparam int CLK_PS     = 40000;
   // least time rounds up, longest rounds down; neither below one cycle
   localparam int TAA_MIN_CYC_RAW = (TAA_MIN_PS + CLK_PS - 1) / CLK_PS;
   localparam int TAA_MAX_CYC_RAW = TAA_MAX_PS / CLK_PS;
   localparam int TAA_MIN_CYC = (TAA_MIN_CYC_RAW < 1) ? 1 : TAA_MIN_CYC_RAW;
   localparam int TAA_MAX_CYC = (TAA_MAX_CYC_RAW < 1) ? 1 : TAA_MAX_CYC_RAW;
   localparam logic [3:0] RD_LAT = 4'(TAA_MIN_CYC);
   // burst lengths in beats
   localparam logic [3:0] BEATS_BL8 = 4'h8;
   localparam logic [3:0] BEATS_BC4 = 4'h4;
   typedef enum logic [3:0] {
      DCD_DESELECT, DCD_NOP, DCD_READ, DCD_WRITE, DCD_ACTIVATE, DCD_PRECHARGE,
      DCD_MRS, DCD_REFRESH, DCD_SR_ENTER, DCD_SR_EXIT, DCD_PD_ENTER, DCD_PD_EXIT,
      DCD_ZQ, DCD_ILLEGAL
   } dcd_cmd_type;
endpackage : dcd_pkg

/* core/dcd_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// two-flop synchroniser for pins from outside the clock domain
module dcd_sync
   import dcd_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] din,
   output var  logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_ff;

   // first stage is read only by the second stage
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_ff <= '0;
         dout    <= '0;
      end else begin
         meta_ff <= din;
         dout    <= meta_ff;
      end
   end
endmodule // dcd_sync
`default_nettype wire

/* core/dcd_decode.sv */
// Overview of operation
// R1: decode command at link clock rising edge
// R2: read encoding; A10 selects auto-precharge
// R3: write encoding; A10 selects auto-precharge
// R4: on-the-fly A12 picks chop or eight
// R5: bank lines pick bank or mode register
// R6: active-low reset acts asynchronously only
// R7: bursts run to completion, never interrupted
// R8: no refresh performed during power-down
// R9: termination ignored in decode and self-refresh
// R10: self-refresh exits asynchronously on enable rise
// R11: controller waits 512 clocks before write
// R12: no-op never ends running burst
// R13: chip select high acts as no-op
// R14: controller honours activate-to-column delay
// R15: controller honours bank open time limits
// R16: controller honours activate-to-activate spacing
// R17: read data no earlier than latency
// R18: controller picks period meeting both latencies
// R19: latency rounds up to supported setting
// R20: controller never programs reserved latency
// R21: latency 13 only in fastest bin
// R22: latency 5 allowed period 3.0-3.3ns
// R23: only no-op while enable changes
// R24: self-refresh entry only when idle
// R25: only no-op during self-refresh exit
`timescale 1ns/10ps
`default_nettype none
module dcd_decode
   import dcd_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        ck_pin,
   input  wire logic        cke_pin,
   input  wire logic        cs_n_pin,
   input  wire logic        ras_n_pin,
   input  wire logic        cas_n_pin,
   input  wire logic        we_n_pin,
   input  wire logic [2:0]  ba_pin,
   input  wire logic [15:0] addr_pin,
   input  wire logic        odt_pin,
   input  wire logic        otf_en,
   input  wire logic        fixed_bc4,
   output var  logic        cmd_valid,
   output var  dcd_cmd_type cmd_code,
   output var  logic [2:0]  cmd_bank,
   output var  logic [15:0] cmd_addr,
   output var  logic        cmd_auto_pre,
   output var  logic        cmd_chop,
   output var  logic        burst_active,
   output var  logic        rd_data_go,
   output var  logic        self_refresh,
   output var  logic        power_down,
   output var  logic        refresh_go,
   output var  logic        odt_active
);
   localparam int PW = 26;

   logic [PW-1:0]  pin_vec;
   logic [PW-1:0]  pin_s;
   logic           ck_s;
   logic           cke_s;
   logic           cs_n_s;
   logic           ras_n_s;
   logic           cas_n_s;
   logic           we_n_s;
   logic [2:0]     ba_s;
   logic [15:0]    addr_s;
   logic           odt_s;
   logic           ck_prev_ff;
   logic [1:0]     ck_fill_ff;
   logic           ck_rise;
   logic           cke_prev_ff;
   logic           in_sr_ff;
   logic           in_pd_ff;
   logic [3:0]     beats_ff;
   logic [3:0]     lat_ff;
   logic           lat_run_ff;
   logic [3:0]     pend_beats_ff;
   dcd_cmd_type    dec;
   logic           is_chop;

   assign pin_vec = {ck_pin, cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin,
                     ba_pin, addr_pin, odt_pin};

   // every pin crosses into clk through two flops
   dcd_sync #(.WIDTH(PW)) u_sync (
      .clk  (clk),
      .nrst (nrst),
      .din  (pin_vec),
      .dout (pin_s)
   );

   assign {ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, addr_s, odt_s} = pin_s;

   // link clock edge detect on the synchronised copy; the sync stages show reset zeros
   // for two clocks, so the previous level is pinned high until they fill, else a link
   // clock parked high would give a false edge after every reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ck_fill_ff <= 2'h0;
         ck_prev_ff <= 1'b1;
      end else begin
         ck_fill_ff <= {ck_fill_ff[0], 1'b1};
         ck_prev_ff <= ck_fill_ff[1] ? ck_s : 1'b1;
      end
   end
   assign ck_rise = ck_s & ~ck_prev_ff;

   // command decode from cs/ras/cas/we and both enable levels; odt plays no part
   function automatic dcd_cmd_type decode_cmd(input logic ke_prev, input logic ke_now,
                                              input logic [3:0] lines, input logic sr_now);
      dcd_cmd_type r;
      r = DCD_ILLEGAL;
      if (!ke_prev && ke_now) begin
         r = (lines[3] || lines == CMD_NOP) ? ((sr_now) ? DCD_SR_EXIT : DCD_PD_EXIT) : DCD_ILLEGAL;
      end else if (!ke_prev) begin
         r = DCD_NOP;                                  // held low: pins are don't care
      end else if (!ke_now) begin
         if (!lines[3] && lines == CMD_REF) r = DCD_SR_ENTER;
         else if (lines[3] || lines == CMD_NOP) r = DCD_PD_ENTER;
      end else if (lines[3]) begin
         r = DCD_DESELECT;                             // R13
      end else begin
         unique case (lines[2:0])
            CMD_NOP[2:0]:  r = DCD_NOP;
            CMD_RDWR[2:0]: r = DCD_READ;               // R2
            CMD_WR[2:0]:   r = DCD_WRITE;              // R3
            CMD_ACT[2:0]:  r = DCD_ACTIVATE;
            CMD_PRE[2:0]:  r = DCD_PRECHARGE;
            CMD_REF[2:0]:  r = DCD_REFRESH;
            CMD_MRS[2:0]:  r = DCD_MRS;
            CMD_ZQ[2:0]:   r = DCD_ZQ;
         endcase
      end
      return r;
   endfunction

   // state is an argument so the assignment re-evaluates when it changes
   assign dec = decode_cmd(cke_prev_ff, cke_s, {cs_n_s, ras_n_s, cas_n_s, we_n_s}, in_sr_ff); // R1

   // chop chosen by A12 when on-the-fly, else by the fixed mode
   assign is_chop = otf_en ? ~addr_s[BC_BIT] : fixed_bc4; // R4

   // previous enable level, sampled only at link edges
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cke_prev_ff <= 1'b0;
      end else if (ck_rise) begin
         cke_prev_ff <= cke_s;
      end
   end

   // self-refresh exit follows the enable level itself, not a link edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         in_sr_ff <= 1'b0;
      end else if (cke_s && in_sr_ff) begin
         in_sr_ff <= 1'b0;                              // R10
      end else if (ck_rise && dec == DCD_SR_ENTER) begin
         in_sr_ff <= 1'b1;
      end
   end

   // power-down state tracking
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         in_pd_ff <= 1'b0;
      end else if (ck_rise) begin
         if (dec == DCD_PD_ENTER) in_pd_ff <= 1'b1;
         else if (dec == DCD_PD_EXIT) in_pd_ff <= 1'b0;
      end
   end

   // decoded command register, one clk pulse per link edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cmd_valid    <= 1'b0;
         cmd_code     <= DCD_DESELECT;            // R6
         cmd_bank     <= 3'h0;
         cmd_addr     <= 16'h0;
         cmd_auto_pre <= 1'b0;
         cmd_chop     <= 1'b0;
      end else begin
         cmd_valid <= ck_rise;
         if (ck_rise) begin
            cmd_code     <= dec;
            cmd_bank     <= ba_s;                       // R5
            cmd_addr     <= addr_s;
            cmd_auto_pre <= addr_s[AP_BIT];              // R2 R3
            cmd_chop     <= is_chop;
         end
      end
   end

   // burst beats count at link edges; nothing but reset stops them
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         beats_ff <= 4'h0;
      end else if (ck_rise) begin
         if (dec == DCD_WRITE && beats_ff == 4'h0) begin
            beats_ff <= is_chop ? BEATS_BC4 : BEATS_BL8;
         end else if (beats_ff != 4'h0) begin
            beats_ff <= beats_ff - 4'h1;                 // R7 R12
         end else if (lat_run_ff && lat_ff == 4'h1) begin
            beats_ff <= pend_beats_ff;
         end
      end
   end
   assign burst_active = (beats_ff != 4'h0);

   // read latency: data starts only after the minimum link clocks
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lat_ff        <= 4'h0;
         lat_run_ff    <= 1'b0;
         pend_beats_ff <= 4'h0;
      end else if (ck_rise) begin
         if (dec == DCD_READ && !lat_run_ff && beats_ff == 4'h0) begin
            lat_ff        <= RD_LAT;                     // R17
            lat_run_ff    <= 1'b1;
            pend_beats_ff <= is_chop ? BEATS_BC4 : BEATS_BL8;
         end else if (lat_run_ff) begin
            lat_ff     <= lat_ff - 4'h1;
            lat_run_ff <= (lat_ff != 4'h1);
         end
      end
   end

   // single pulse when first read data may leave
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_data_go <= 1'b0;
      end else begin
         rd_data_go <= ck_rise && lat_run_ff && lat_ff == 4'h1;
      end
   end

   // refresh runs only when awake; power-down suppresses it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         refresh_go <= 1'b0;
      end else begin
         refresh_go <= ck_rise && dec == DCD_REFRESH && !in_pd_ff; // R8
      end
   end

   // termination is off from one clk after self-refresh starts until one clk after it ends
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         odt_active <= 1'b0;
      end else begin
         odt_active <= odt_s && !in_sr_ff;              // R9
      end
   end

   assign self_refresh = in_sr_ff;
   assign power_down   = in_pd_ff;

   // a running burst keeps counting across no-ops
   a_burst_no_stop: assert property (@(posedge clk) disable iff (!nrst) // R12
      (ck_rise && beats_ff > 4'h1) |=> beats_ff == $past(beats_ff) - 4'h1)
      else $error("burst count stopped or skipped");

   // read data waits the full latency
   a_rd_latency: assert property (@(posedge clk) disable iff (!nrst) // R17
      (ck_rise && dec == DCD_READ && !lat_run_ff && beats_ff == 4'h0) |=> lat_ff == RD_LAT)
      else $error("read latency not loaded");

   // no refresh while powered down
   a_pd_no_refresh: assert property (@(posedge clk) disable iff (!nrst) // R8
      $past(in_pd_ff) && in_pd_ff |-> !refresh_go)
      else $error("refresh during power-down");

   // termination inactive from the second clk of self-refresh on
   a_sr_no_odt: assert property (@(posedge clk) disable iff (!nrst) // R9
      in_sr_ff ##1 in_sr_ff |-> !odt_active)
      else $error("odt active in self-refresh");

   // self-refresh ends within one clk of enable rising
   a_sr_exit_async: assert property (@(posedge clk) disable iff (!nrst) // R10
      (in_sr_ff && cke_s) |=> !in_sr_ff)
      else $error("self-refresh exit stalled");

   // chip select high decodes as deselect
   a_cs_deselect: assert property (@(posedge clk) disable iff (!nrst) // R13
      (ck_rise && cke_s && cke_prev_ff && cs_n_s) |=> cmd_valid && cmd_code == DCD_DESELECT)
      else $error("deselect not decoded");

   // auto-precharge follows A10 on column commands
   a_ap_bit: assert property (@(posedge clk) disable iff (!nrst) // R2
      (ck_rise && (dec == DCD_READ || dec == DCD_WRITE)) |=> cmd_auto_pre == $past(addr_s[AP_BIT]))
      else $error("auto-precharge bit wrong");

   // bank follows bank lines
   a_bank_sel: assert property (@(posedge clk) disable iff (!nrst) // R5
      ck_rise |=> cmd_bank == $past(ba_s))
      else $error("bank select wrong");

   // on-the-fly A12 low selects chop
   a_otf_chop: assert property (@(posedge clk) disable iff (!nrst) // R4
      (ck_rise && otf_en && dec == DCD_WRITE) |=> cmd_chop == !$past(addr_s[BC_BIT]))
      else $error("chop select wrong");

   // write burst length loaded per chop
   a_write_len: assert property (@(posedge clk) disable iff (!nrst) // R3
      (ck_rise && dec == DCD_WRITE && beats_ff == 4'h0) |=> beats_ff == (cmd_chop ? BEATS_BC4 : BEATS_BL8))
      else $error("write burst length wrong");
endmodule // dcd_decode
`default_nettype wire

/* bench/dcd_ctrl_model.sv */
`timescale 1ns/10ps
`default_nettype none
// memory controller side: drives the command pins, one command per link frame
module dcd_ctrl_model
   import dcd_pkg::*;
(
   input  wire logic        clk,
   output var  logic        ck_pin,
   output var  logic        cke_pin,
   output var  logic        cs_n_pin,
   output var  logic        ras_n_pin,
   output var  logic        cas_n_pin,
   output var  logic        we_n_pin,
   output var  logic [2:0]  ba_pin,
   output var  logic [15:0] addr_pin
);
   // cke starts low as after power-up; the link clock stands still outside frames
   initial begin
      {ck_pin, cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} = 6'h0f;
      ba_pin = 3'h0;
      addr_pin = 16'h0000;
   end
   // 320 ns frame: pins change at the fall, settle 4 clk, are taken at the rise, held 4 clk
   task automatic frame(input logic [3:0] lines, input logic [2:0] ba, input logic [15:0] addr, input logic cke);
      @(posedge clk);
      ck_pin <= 1'b0;
      cke_pin <= cke;
      {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} <= lines;
      // a deselected device sees no defined address, so show the inverse of the last one
      ba_pin <= lines[3] ? ~ba_pin : ba;
      addr_pin <= lines[3] ? ~addr_pin : addr;
      repeat (4) @(posedge clk);
      ck_pin <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   // clock enable alone, with the link clock stopped, as for leaving self refresh
   task automatic set_cke(input logic lvl);
      @(posedge clk);
      cke_pin <= lvl;
   endtask
endmodule // dcd_ctrl_model
`default_nettype wire

/* bench/ddr3_command_decode_timing_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module ddr3_command_decode_timing_tb
   import dcd_pkg::*;
;
   logic        clk, nrst, odt_pin, otf_en, fixed_bc4;
   logic        ck_pin, cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin;
   logic [2:0]  ba_pin, cmd_bank;
   logic [15:0] addr_pin, cmd_addr;
   logic        cmd_valid, cmd_auto_pre, cmd_chop, burst_active, rd_data_go;
   logic        self_refresh, power_down, refresh_go, odt_active;
   dcd_cmd_type cmd_code;
   int          err_total, cmp_count, n_valid, n_rd, n_ref, n_ref_pd, cyc, k;
   logic [3:0]  tbl_lines [8] = '{CMD_ACT, CMD_PRE, CMD_MRS, CMD_REF, CMD_ZQ, CMD_NOP, 4'hf, 4'h8};
   dcd_cmd_type tbl_code [8] = '{DCD_ACTIVATE, DCD_PRECHARGE, DCD_MRS, DCD_REFRESH, DCD_ZQ, DCD_NOP,
                                 DCD_DESELECT, DCD_DESELECT};

   dcd_ctrl_model dcd_ctrl_model_i (.clk, .ck_pin, .cke_pin, .cs_n_pin, .ras_n_pin, .cas_n_pin, .we_n_pin,
                                    .ba_pin, .addr_pin);
   dcd_decode dcd_decode_i (.clk, .nrst, .ck_pin, .cke_pin, .cs_n_pin, .ras_n_pin, .cas_n_pin, .we_n_pin,
                            .ba_pin, .addr_pin, .odt_pin, .otf_en, .fixed_bc4, .cmd_valid, .cmd_code,
                            .cmd_bank, .cmd_addr, .cmd_auto_pre, .cmd_chop, .burst_active, .rd_data_go,
                            .self_refresh, .power_down, .refresh_go, .odt_active);

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // pulses stand one clk, so they are counted here rather than polled
   always @(posedge clk) begin
      n_valid <= n_valid + int'(cmd_valid === 1'b1);
      n_rd <= n_rd + int'(rd_data_go === 1'b1);
      n_ref <= n_ref + int'(refresh_go === 1'b1);
      n_ref_pd <= n_ref_pd + int'(refresh_go === 1'b1 && power_down === 1'b1);
   end
   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         err_total++;
         report_and_stop();
      end
   end

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   // one frame, then the decoded code and exactly one valid pulse
   task automatic cmd_chk(input logic [3:0] ln, input logic [2:0] ba, input logic [15:0] ad, input logic cke,
                          input dcd_cmd_type exp);
      int v0;
      v0 = n_valid;
      dcd_ctrl_model_i.frame(ln, ba, ad, cke);
      repeat (3) @(posedge clk);
      chk("cmd_code", 16'(exp), 16'(cmd_code));
      chk("cmd_valid pulses", 16'(v0 + 1), 16'(n_valid));
   endtask
   task automatic nops(input int n);
      repeat (n) dcd_ctrl_model_i.frame(CMD_NOP, 3'h0, 16'h0000, 1'b1);
      repeat (2) @(posedge clk); // let the last edge's pulses reach the counters
   endtask

   // every plain command, bank lines walking, termination request high throughout
   task automatic s_table();
      int r0;
      r0 = n_ref;
      odt_pin <= 1'b1;
      for (k = 0; k < 8; k++) begin
         cmd_chk(tbl_lines[k], 3'(k), 16'h0400, 1'b1, tbl_code[k]);
         if (k < 5) chk("cmd_bank", 16'(k), 16'(cmd_bank));
      end
      chk("refresh pulses", 16'(r0 + 1), 16'(n_ref));
   endtask
   // a chopped auto-precharge read, then an on-the-fly eight-beat write without precharge and a fixed-chop write with it
   task automatic s_rdwr();
      int r0;
      otf_en <= 1'b1;
      r0 = n_rd;
      cmd_chk(CMD_RDWR, 3'h5, 16'h0423, 1'b1, DCD_READ);
      chk("read fields", 16'hbc23, {cmd_bank, cmd_auto_pre, cmd_chop, cmd_addr[10:0]});
      chk("no early data", 16'(r0), 16'(n_rd));
      nops(1);
      chk("data start", 16'(r0 + 1), 16'(n_rd));
      chk("burst after nop", 16'h0001, 16'(burst_active));
      nops(10);
      chk("burst done", 16'h0000, 16'(burst_active));
      cmd_chk(CMD_WR, 3'h2, 16'h1011, 1'b1, DCD_WRITE);
      chk("write fields", 16'h0200, {5'h0, cmd_bank, cmd_auto_pre, cmd_chop, 6'h0});
      nops(10);
      otf_en <= 1'b0;
      fixed_bc4 <= 1'b1;
      cmd_chk(CMD_WR, 3'h1, 16'h1400, 1'b1, DCD_WRITE);
      chk("fixed chop", 16'h0003, {14'h0, cmd_auto_pre, cmd_chop});
      nops(10);
   endtask
   // power-down: no refresh runs while the enable stays low
   task automatic s_pd();
      int r0;
      r0 = n_ref;
      cmd_chk(CMD_NOP, 3'h0, 16'h0000, 1'b0, DCD_PD_ENTER);
      chk("power_down", 16'h0001, 16'(power_down));
      dcd_ctrl_model_i.frame(CMD_REF, 3'h0, 16'h0000, 1'b0);
      repeat (2) @(posedge clk);
      chk("refresh in pd", 16'(r0), 16'(n_ref));
      cmd_chk(CMD_NOP, 3'h0, 16'h0000, 1'b1, DCD_PD_EXIT);
      chk("power_down off", 16'h0000, 16'(power_down));
   endtask
   // self refresh: termination off inside, exit on the enable alone
   task automatic s_sr();
      cmd_chk(CMD_REF, 3'h0, 16'h0000, 1'b0, DCD_SR_ENTER);
      chk("sr and odt", 16'h0002, {14'h0, self_refresh, odt_active});
      dcd_ctrl_model_i.set_cke(1'b1);
      for (k = 0; k < 10 && self_refresh !== 1'b0; k++) @(posedge clk);
      chk("sr exit", 16'h0000, 16'(self_refresh));
      nops(2);
      chk("odt back", 16'h0001, 16'(odt_active));
   endtask
   // reset while a read waits out its latency clears everything at once, without a clock edge
   task automatic s_reset();
      int v0;
      dcd_ctrl_model_i.frame(CMD_RDWR, 3'h3, 16'h0000, 1'b1);
      @(posedge clk);
      nrst <= 1'b0;
      #1;
      chk("outputs in reset", 16'h0000, {9'h0, cmd_valid, burst_active, rd_data_go, self_refresh, power_down,
                                          refresh_go, odt_active});
      chk("code in reset", 16'(DCD_DESELECT), 16'(cmd_code));
      @(posedge clk);
      nrst <= 1'b1;
      // the link clock is parked high here: no command may appear until a real edge
      @(posedge clk);
      v0 = n_valid;
      repeat (6) @(posedge clk);
      chk("valid after reset", 16'(v0), 16'(n_valid));
      cmd_chk(CMD_NOP, 3'h0, 16'h0000, 1'b1, DCD_PD_EXIT);
   endtask

   task automatic report_and_stop();
      if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      {nrst, odt_pin, otf_en, fixed_bc4} = 4'h0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      chk("idle outputs", 16'h0000, {9'h0, cmd_valid, burst_active, rd_data_go, self_refresh, power_down,
                                      refresh_go, odt_active});
      cmd_chk(CMD_NOP, 3'h0, 16'h0000, 1'b1, DCD_PD_EXIT);
      s_table();
      s_rdwr();
      s_pd();
      s_sr();
      chk("refresh while down", 16'h0000, 16'(n_ref_pd));
      s_reset();
      report_and_stop();
   end
endmodule // ddr3_command_decode_timing_tb
`default_nettype wire
